// File: common/pmcap_defines.vh
// Offsets, field positions, reset values and constants of the capability bank
`ifndef PMCAP_DEFINES_VH
`define PMCAP_DEFINES_VH
`define PMCAP_OFF_PMCSR      8'h84
`define PMCAP_OFF_MSICTL     8'h8c
`define PMCAP_OFF_MSIADDR    8'h90
`define PMCAP_OFF_MSIUADDR   8'h94
`define PMCAP_OFF_MSIDATA    8'h98
`define PMCAP_OFF_VPDCAP     8'h9c
`define PMCAP_PS_D0          2'h0
`define PMCAP_PS_D3HOT       2'h3
`define PMCAP_PS_RST         2'h0
`define PMCAP_BIT_NOSOFT     3
`define PMCAP_BIT_PME_EN     8
`define PMCAP_BIT_PME_ST     15
`define PMCAP_BIT_MSI_EN     16
`define PMCAP_BIT_MSI64      23
`define PMCAP_DSEL_HI        12
`define PMCAP_DSEL_LO        9
`define PMCAP_MME_HI         22
`define PMCAP_MME_LO         20
`define PMCAP_MSI_CAP_ID     8'h05
`define PMCAP_MSI_NEXT       8'h9c
`define PMCAP_VPD_CAP_ID     8'h03
`define PMCAP_VPD_NEXT       8'ha4
`define PMCAP_HOT_RST_CYC    4'h8
`define PMCAP_MWR_WAIT_CYC   8'h40
`endif

// File: core/pmcap_sync3.v
// Three-flop synchroniser for an asynchronous pin level
`include "pmcap_defines.vh"
module pmcap_sync3 (
  input  wire sys_clk_in,
  input  wire reset_n_in,
  input  wire async_in,
  output reg  level_out
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  // ------------------------------------------------------------
  // Sync chain, change taken when second and third agree
  // ------------------------------------------------------------
  always @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      // Idle level of the pin, no false reset after release
      s1_q      <= 1'b1;
      s2_q      <= 1'b1;
      s3_q      <= 1'b1;
      level_out <= 1'b1;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_out <= s3_q;
      end
    end
  end
endmodule

// File: core/pmcap_msi_issue.v
// Interrupt request sequencer: MSI memory write or legacy level
`include "pmcap_defines.vh"
module pmcap_msi_issue (
  input  wire        sys_clk_in,
  input  wire        reset_n_in,
  input  wire        irq_req_in,
  input  wire        msi_en_in,
  input  wire [63:0] addr_in,
  input  wire [15:0] data_in,
  input  wire        mwr_ack_in,
  output reg         mwr_req_out,
  output reg  [63:0] mwr_addr_out,
  output reg  [15:0] mwr_data_out,
  output reg         intx_out
);
  localparam ST_IDLE = 2'b01;
  localparam ST_SEND = 2'b10;
  reg [1:0] state_q;
  reg       pend_q;
  // ------------------------------------------------------------
  // Pending capture, set wins over clear
  // ------------------------------------------------------------
  always @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      pend_q       <= 1'b0;
      state_q      <= ST_IDLE;
      mwr_req_out  <= 1'b0;
      mwr_addr_out <= 64'h0;
      mwr_data_out <= 16'h0;
      intx_out     <= 1'b0;
    end else begin
      intx_out <= irq_req_in & ~msi_en_in; // Legacy only while MSI is off
      case (state_q)
        ST_IDLE: begin
          if (msi_en_in && (irq_req_in || pend_q)) begin
            mwr_req_out  <= 1'b1;
            mwr_addr_out <= addr_in;
            mwr_data_out <= data_in;
            pend_q       <= 1'b0;
            state_q      <= ST_SEND;
          end else if (!msi_en_in) begin
            pend_q <= 1'b0;
          end
        end
        ST_SEND: begin
          if (irq_req_in) begin
            pend_q <= 1'b1;
          end
          if (mwr_ack_in) begin
            mwr_req_out <= 1'b0;
            state_q     <= ST_IDLE;
          end
        end
        default: begin
          state_q     <= ST_IDLE;
          mwr_req_out <= 1'b0;
        end
      endcase
    end
  end
endmodule

// File: core/pmcap_regs.v
// Power management, MSI and VPD header capability register bank
// Functional notes
// - Power state is a two-bit writable field with D0..D3hot as 0..3.
// - Writing D0 while in D3hot fires an internal hot reset without the reset pin.
// - Read-only bit 3 reports whether the D3hot to D0 move skips the internal reset.
// - The reset-skip bit clears at reset and may then take a value loaded from EEPROM.
// - Power event messages go out only while writable enable bit 8 is set, reset zero.
// - Read-only bit 15 is set while a power event message is pending, reset zero.
// - Bridge extension bits for B2/B3 and bus power control always read zero.
// - The MSI structure first byte reads 05h.
// - The MSI next pointer reads 9Ch.
// - MSI enable resets to zero and chooses between MSI and the legacy interrupt.
// - MSI control bit 23 reads one to show 64-bit addressing.
// - Message address keeps bits 31:2 writable and bits 1:0 read zero.
// - Upper message address is a writable word, reset zero, used as the high half.
// - The VPD structure first byte reads 03h.
`include "pmcap_defines.vh"
module pmcap_regs (
  input  wire        sys_clk_in,
  input  wire        reset_n_in,
  input  wire        fundamental_reset_in_n,
  input  wire        cfg_wr_in,
  input  wire        cfg_rd_in,
  input  wire [7:0]  cfg_addr_in,
  input  wire [3:0]  cfg_be_in,
  input  wire [31:0] cfg_wdata_in,
  output reg  [31:0] cfg_rdata_out,
  output reg         cfg_rvalid_out,
  input  wire        eeprom_load_in,
  input  wire        eeprom_nosoft_in,
  input  wire        pme_event_in,
  input  wire        pme_sent_in,
  output reg         pme_req_out,
  input  wire        irq_req_in,
  input  wire        mwr_ack_in,
  output reg         mwr_req_out,
  output reg  [63:0] mwr_addr_out,
  output reg  [15:0] mwr_data_out,
  output reg         intx_out,
  output reg         hot_reset_out
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  reg  [1:0]  pstate_q;
  reg         nosoft_q;
  reg         pme_en_q;
  reg         pme_st_q;
  reg  [3:0]  dsel_q;
  reg         msi_en_q;
  reg  [2:0]  mme_q;
  reg  [29:0] maddr_q;
  reg  [31:0] muaddr_q;
  reg  [15:0] mdata_q;
  reg  [3:0]  hrst_cnt_q;
  reg  [31:0] rdata_d;
  wire        perst_lvl;
  wire        mwr_req_w;
  wire [63:0] mwr_addr_w;
  wire [15:0] mwr_data_w;
  wire        intx_w;
  wire        wr_pmcsr;
  wire        wr_msictl;
  wire        wr_msiaddr;
  wire        wr_msiuaddr;
  wire        wr_msidata;
  wire        hrst_load_w;
  wire        hrst_fire_w;
  wire [31:0] maddr_mrg;
  wire [31:0] mdata_mrg;
  wire [31:0] pm_word_w;
  wire [31:0] ctl_word_w;
  wire [31:0] vpd_word_w;

  // Byte-lane merge of a write into an old word
  function [31:0] be_merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0]  be;
    begin
      be_merge = {be[3] ? wd[31:24] : old[31:24], be[2] ? wd[23:16] : old[23:16],
                  be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    end
  endfunction

  // Write hit on one register offset
  function reg_hit;
    input       wr;
    input [7:0] addr;
    input [7:0] off;
    begin
      reg_hit = wr && (addr == off);
    end
  endfunction

  // D3hot to D0 move that needs the internal reset
  function wake_reset;
    input [1:0] old_ps;
    input [1:0] new_ps;
    input       skip;
    begin
      wake_reset = (old_ps == `PMCAP_PS_D3HOT) && (new_ps == `PMCAP_PS_D0) && !skip;
    end
  endfunction

  // ------------------------------------------------------------
  // Pin synchroniser for external fundamental reset
  // ------------------------------------------------------------
  pmcap_sync3 u_perst (
    .sys_clk_in (sys_clk_in),
    .reset_n_in (reset_n_in),
    .async_in   (fundamental_reset_in_n),
    .level_out  (perst_lvl)
  );

  // ------------------------------------------------------------
  // Interrupt delivery
  // ------------------------------------------------------------
  pmcap_msi_issue u_msi (
    .sys_clk_in   (sys_clk_in),
    .reset_n_in   (reset_n_in),
    .irq_req_in   (irq_req_in),
    .msi_en_in    (msi_en_q),
    .addr_in      ({muaddr_q, maddr_q, 2'b00}),
    .data_in      (mdata_q),
    .mwr_ack_in   (mwr_ack_in),
    .mwr_req_out  (mwr_req_w),
    .mwr_addr_out (mwr_addr_w),
    .mwr_data_out (mwr_data_w),
    .intx_out     (intx_w)
  );

  // ------------------------------------------------------------
  // Write strobes and byte-lane merges
  // ------------------------------------------------------------
  // One strobe per writable offset, other writes fall through
  assign wr_pmcsr    = reg_hit(cfg_wr_in, cfg_addr_in, `PMCAP_OFF_PMCSR);
  assign wr_msictl   = reg_hit(cfg_wr_in, cfg_addr_in, `PMCAP_OFF_MSICTL);
  assign wr_msiaddr  = reg_hit(cfg_wr_in, cfg_addr_in, `PMCAP_OFF_MSIADDR);
  assign wr_msiuaddr = reg_hit(cfg_wr_in, cfg_addr_in, `PMCAP_OFF_MSIUADDR);
  assign wr_msidata  = reg_hit(cfg_wr_in, cfg_addr_in, `PMCAP_OFF_MSIDATA);
  // Merged words, only the stored bits are taken
  assign maddr_mrg = be_merge({maddr_q, 2'b00}, cfg_wdata_in, cfg_be_in);
  assign mdata_mrg = be_merge({16'h0, mdata_q}, cfg_wdata_in, cfg_be_in);

  // ------------------------------------------------------------
  // Hot reset decode
  // ------------------------------------------------------------
  // Load on a D3hot to D0 write unless the skip flag is set
  assign hrst_load_w = wr_pmcsr && cfg_be_in[0]
                       && wake_reset(pstate_q, cfg_wdata_in[1:0], nosoft_q);
  // First counted cycle clears the MSI state once
  assign hrst_fire_w = (hrst_cnt_q == `PMCAP_HOT_RST_CYC);

  // ------------------------------------------------------------
  // Read words
  // ------------------------------------------------------------
  // Power word: reserved, bridge extensions and data byte read zero
  assign pm_word_w  = {8'h00, 8'h00, pme_st_q, 2'b00, dsel_q, pme_en_q,
                       4'h0, nosoft_q, 1'b0, pstate_q};
  // Control word: fixed 64-bit flag, next pointer and identifier
  assign ctl_word_w = {8'h00, 1'b1, mme_q, 3'b000, msi_en_q,
                       `PMCAP_MSI_NEXT, `PMCAP_MSI_CAP_ID};
  // Header of the following structure
  assign vpd_word_w = {16'h0, `PMCAP_VPD_NEXT, `PMCAP_VPD_CAP_ID};

  // ------------------------------------------------------------
  // Power management control and status
  // ------------------------------------------------------------
  always @(posedge sys_clk_in) begin
    if (!reset_n_in || !perst_lvl) begin
      pstate_q   <= `PMCAP_PS_RST;
      hrst_cnt_q <= 4'h0;
    end else begin
      if (wr_pmcsr && cfg_be_in[0]) begin
        pstate_q <= cfg_wdata_in[1:0];
      end
      // Pulse counter, a new wake restarts it
      if (hrst_load_w) begin
        hrst_cnt_q <= `PMCAP_HOT_RST_CYC;
      end else if (hrst_cnt_q != 4'h0) begin
        hrst_cnt_q <= hrst_cnt_q - 4'h1;
      end
    end
  end

  // Reset-skip flag, EEPROM auto-load replaces the default
  always @(posedge sys_clk_in) begin
    if (!reset_n_in || !perst_lvl) begin
      nosoft_q <= 1'b0;
    end else if (eeprom_load_in) begin
      nosoft_q <= eeprom_nosoft_in;
    end
  end

  // Event enable and data select, byte lane 1 of the power word
  always @(posedge sys_clk_in) begin
    if (!reset_n_in || !perst_lvl) begin
      pme_en_q <= 1'b0;
      dsel_q   <= 4'h0;
    end else if (wr_pmcsr && cfg_be_in[1]) begin
      pme_en_q <= cfg_wdata_in[`PMCAP_BIT_PME_EN];
      dsel_q   <= cfg_wdata_in[`PMCAP_DSEL_HI:`PMCAP_DSEL_LO];
    end
  end

  // Pending flag, new event wins over delivery
  always @(posedge sys_clk_in) begin
    if (!reset_n_in || !perst_lvl) begin
      pme_st_q <= 1'b0;
    end else if (pme_event_in) begin
      pme_st_q <= 1'b1;
    end else if (pme_sent_in) begin
      pme_st_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // MSI registers
  // ------------------------------------------------------------
  always @(posedge sys_clk_in) begin
    if (!reset_n_in || !perst_lvl || hrst_fire_w) begin
      msi_en_q <= 1'b0;
      mme_q    <= 3'h0;
      maddr_q  <= 30'h0;
      muaddr_q <= 32'h0;
      mdata_q  <= 16'h0;
    end else begin
      if (wr_msictl && cfg_be_in[2]) begin
        msi_en_q <= cfg_wdata_in[`PMCAP_BIT_MSI_EN];
        mme_q    <= cfg_wdata_in[`PMCAP_MME_HI:`PMCAP_MME_LO];
      end
      if (wr_msiaddr) begin
        maddr_q <= maddr_mrg[31:2];
      end
      if (wr_msiuaddr) begin
        muaddr_q <= be_merge(muaddr_q, cfg_wdata_in, cfg_be_in);
      end
      if (wr_msidata) begin
        mdata_q <= mdata_mrg[15:0];
      end
    end
  end

  // ------------------------------------------------------------
  // Read decode, unmapped and reserved read zero
  // ------------------------------------------------------------
  always @* begin
    rdata_d = 32'h0;
    case (cfg_addr_in)
      `PMCAP_OFF_PMCSR:    rdata_d = pm_word_w;
      `PMCAP_OFF_MSICTL:   rdata_d = ctl_word_w;
      `PMCAP_OFF_MSIADDR:  rdata_d = {maddr_q, 2'b00};
      `PMCAP_OFF_MSIUADDR: rdata_d = muaddr_q;
      `PMCAP_OFF_MSIDATA:  rdata_d = {16'h0, mdata_q};
      `PMCAP_OFF_VPDCAP:   rdata_d = vpd_word_w;
      default:             rdata_d = 32'h0;
    endcase
  end

  // ------------------------------------------------------------
  // Registered outputs
  // ------------------------------------------------------------
  // Read answer one cycle after the strobe, data held to the next read
  always @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      cfg_rdata_out  <= 32'h0;
      cfg_rvalid_out <= 1'b0;
    end else begin
      cfg_rvalid_out <= cfg_rd_in;
      if (cfg_rd_in) begin
        cfg_rdata_out <= rdata_d;
      end
    end
  end

  // Event request only while the enable is set
  always @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      pme_req_out <= 1'b0;
    end else begin
      pme_req_out <= pme_st_q & pme_en_q;
    end
  end

  // Message write, request falls with the accept so it is taken once
  always @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      mwr_req_out  <= 1'b0;
      mwr_addr_out <= 64'h0;
      mwr_data_out <= 16'h0;
    end else begin
      mwr_req_out  <= mwr_req_w & ~mwr_ack_in;
      mwr_addr_out <= mwr_addr_w;
      mwr_data_out <= mwr_data_w;
    end
  end

  // Legacy level and hot reset pulse
  always @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      intx_out      <= 1'b0;
      hot_reset_out <= 1'b0;
    end else begin
      intx_out      <= intx_w;
      hot_reset_out <= (hrst_cnt_q != 4'h0);
    end
  end
endmodule

// File: verification/pmcap_regs_monitor.sv
// Port checks for the capability register bank
module pmcap_regs_monitor (
  input wire logic        sys_clk_in,
  input wire logic        reset_n_in,
  input wire logic        cfg_rd_in,
  input wire logic [7:0]  cfg_addr_in,
  input wire logic [31:0] cfg_rdata_out,
  input wire logic        cfg_rvalid_out,
  input wire logic        mwr_ack_in,
  input wire logic        mwr_req_out,
  input wire logic [63:0] mwr_addr_out,
  input wire logic        hot_reset_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  // ----------
  // Assertions
  // ----------
  property p_rvalid; cfg_rvalid_out == $past(cfg_rd_in); endproperty
  a_rvalid: assert property (p_rvalid) else $error("read answer timing off");
  property p_pm; cfg_rd_in && cfg_addr_in == 8'h84 |=> (cfg_rdata_out & 32'hffff60f4) == 0;
  endproperty
  a_pm: assert property (p_pm) else $error("power word fixed bits set");
  property p_ctl; cfg_rd_in && cfg_addr_in == 8'h8c
    |=> (cfg_rdata_out & 32'hff8effff) == 32'h00809c05; endproperty
  a_ctl: assert property (p_ctl) else $error("msi header wrong");
  property p_vpd; cfg_rd_in && cfg_addr_in == 8'h9c |=> cfg_rdata_out[7:0] == 8'h03;
  endproperty
  a_vpd: assert property (p_vpd) else $error("vpd header wrong");
  property p_alo; cfg_rd_in && cfg_addr_in == 8'h90 |=> cfg_rdata_out[1:0] == 2'h0;
  endproperty
  a_alo: assert property (p_alo) else $error("address low bits set");
  property p_mal; mwr_req_out |-> mwr_addr_out[1:0] == 2'h0; endproperty
  a_mal: assert property (p_mal) else $error("message write unaligned");
  property p_hold; mwr_req_out && !mwr_ack_in |=> mwr_req_out && $stable(mwr_addr_out);
  endproperty
  a_hold: assert property (p_hold) else $error("message write dropped");
  property p_hot; $rose(hot_reset_out) |-> hot_reset_out [*8] ##1 !hot_reset_out; endproperty
  a_hot: assert property (p_hot) else $error("hot reset length wrong");
endmodule
bind pmcap_regs pmcap_regs_monitor i_mon (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
  .cfg_rd_in(cfg_rd_in), .cfg_addr_in(cfg_addr_in), .cfg_rdata_out(cfg_rdata_out),
  .cfg_rvalid_out(cfg_rvalid_out), .mwr_ack_in(mwr_ack_in), .mwr_req_out(mwr_req_out),
  .mwr_addr_out(mwr_addr_out), .hot_reset_out(hot_reset_out));

// File: verification/pmcap_host_model.sv
// Host-side sink that accepts message writes after a set lag
module pmcap_host_model (
  input  wire logic       sys_clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       mwr_req_in,
  input  wire logic [3:0] lag_in,
  output logic            mwr_ack_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_q;
  logic       done_q;
  // One accept pulse per request, after lag_in cycles
  always @(posedge sys_clk_in) begin
    mwr_ack_out <= 1'b0;
    if (!reset_n_in || !mwr_req_in) begin
      cnt_q  <= 4'h0;
      done_q <= 1'b0;
    end else if (!done_q && cnt_q == lag_in) begin
      mwr_ack_out <= 1'b1;
      done_q      <= 1'b1;
    end else if (!done_q) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule

// File: verification/testbench.sv
// Self-checking bench for the capability register bank
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk_in = 1'b0, reset_n_in = 1'b0, cfg_wr_in = 1'b0, cfg_rd_in = 1'b0;
  logic        eeprom_load_in = 1'b0, eeprom_nosoft_in = 1'b0, pme_event_in = 1'b0;
  logic        pme_sent_in = 1'b0, irq_req_in = 1'b0, cfg_rvalid_out, pme_req_out;
  logic        mwr_ack_in, mwr_req_out, intx_out, hot_reset_out;
  logic        fund_rst_n = 1'b1, p = 1'b0;
  logic [7:0]  cfg_addr_in = 8'h00;
  logic [3:0]  cfg_be_in = 4'h0, lag = 4'h0;
  logic [31:0] cfg_wdata_in = 32'h0, cfg_rdata_out, d;
  logic [63:0] mwr_addr_out;
  logic [15:0] mwr_data_out;
  integer      seed = 32'h02f3, bad_count = 0, compares = 0, i, n, rises = 0;
  // Clock
  always #5 sys_clk_in = ~sys_clk_in;
  pmcap_regs i_dut (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
    .fundamental_reset_in_n(fund_rst_n), .cfg_wr_in(cfg_wr_in), .cfg_rd_in(cfg_rd_in),
    .cfg_addr_in(cfg_addr_in), .cfg_be_in(cfg_be_in), .cfg_wdata_in(cfg_wdata_in),
    .cfg_rdata_out(cfg_rdata_out), .cfg_rvalid_out(cfg_rvalid_out),
    .eeprom_load_in(eeprom_load_in), .eeprom_nosoft_in(eeprom_nosoft_in),
    .pme_event_in(pme_event_in), .pme_sent_in(pme_sent_in), .pme_req_out(pme_req_out),
    .irq_req_in(irq_req_in), .mwr_ack_in(mwr_ack_in), .mwr_req_out(mwr_req_out),
    .mwr_addr_out(mwr_addr_out), .mwr_data_out(mwr_data_out), .intx_out(intx_out),
    .hot_reset_out(hot_reset_out));
  pmcap_host_model i_host (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
    .mwr_req_in(mwr_req_out), .lag_in(lag), .mwr_ack_out(mwr_ack_in));
  task automatic print_verdict;
    if (bad_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic step(input int k = 1);
    repeat (k) @(posedge sys_clk_in);
    #1;
  endtask
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] v);
    cfg_addr_in  = a;
    cfg_be_in    = be;
    cfg_wdata_in = v;
    cfg_wr_in    = 1'b1;
    step();
    cfg_wr_in = 1'b0;
    step();
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    cfg_addr_in = a;
    cfg_rd_in   = 1'b1;
    step();
    cfg_rd_in = 1'b0;
    chk("rvalid", 1'b1, cfg_rvalid_out);
    chk("rdata", e, cfg_rdata_out & m);
    step();
  endtask
  function automatic logic sel(input int w);
    return w == 0 ? mwr_req_out : (w == 1 ? intx_out : hot_reset_out);
  endfunction
  task automatic wait_for(input int w, input int lim);
    n = 0;
    while (sel(w) !== 1'b1 && n < lim) begin
      step();
      n++;
    end
    chk("wait", 1'b1, sel(w));
    if (sel(w) !== 1'b1) print_verdict();
  endtask
  function automatic logic [31:0] exp_pm(input logic [31:0] v);
    return {19'h0, v[12:8], 6'h0, v[1:0]};
  endfunction
  function automatic logic [31:0] exp_ctl(input logic [31:0] v);
    return {8'h0, 1'b1, v[22:20], 3'h0, v[16], 16'h9c05};
  endfunction
  // Main sequence
  initial begin
    step(10);
    reset_n_in = 1'b1;
    step(5);
    rd(8'h84, 32'hffffffff, 32'h0);
    rd(8'h8c, 32'hffffffff, 32'h00809c05);
    rd(8'h90, 32'hffffffff, 32'h0);
    rd(8'h94, 32'hffffffff, 32'h0);
    rd(8'h88, 32'hffffffff, 32'h0);
    for (i = 0; i < 4; i++) begin
      d = $random(seed);
      d[1:0] = i[1:0];
      wr(8'h84, 4'hf, d);
      rd(8'h84, 32'hffffffff, exp_pm(d));
      wr(8'h8c, 4'hf, d);
      rd(8'h8c, 32'hffffffff, exp_ctl(d));
      wr(8'h90, 4'hf, d);
      rd(8'h90, 32'hffffffff, d & 32'hfffffffc);
      wr(8'h94, 4'hf, ~d);
      rd(8'h94, 32'hffffffff, ~d);
      wr(8'h98, 4'hf, d);
      rd(8'h98, 32'hffffffff, d & 32'h0000ffff);
      wr(8'h9c, 4'hf, d);
      rd(8'h9c, 32'h000000ff, 32'h03);
    end
    for (i = 0; i < 2; i++) begin
      wr(8'h84, 4'h2, i ? 32'h0 : 32'h100);
      pme_event_in = 1'b1;
      step();
      pme_event_in = 1'b0;
      step(2);
      chk("pme_req", !i, pme_req_out);
      rd(8'h84, 32'h00008000, 32'h8000);
      pme_sent_in = 1'b1;
      step();
      pme_sent_in = 1'b0;
      step(2);
      chk("pme_req", 1'b0, pme_req_out);
    end
    // Event and delivery in one cycle: the event wins
    pme_event_in = 1'b1;
    pme_sent_in  = 1'b1;
    step();
    pme_event_in = 1'b0;
    pme_sent_in  = 1'b0;
    rd(8'h84, 32'h00008000, 32'h8000);
    pme_sent_in = 1'b1;
    step();
    pme_sent_in = 1'b0;
    rd(8'h84, 32'h00008000, 32'h0);
    d = $random(seed);
    wr(8'h90, 4'hf, d);
    wr(8'h94, 4'hf, ~d);
    wr(8'h98, 4'hf, d);
    wr(8'h8c, 4'h4, 32'h00010000);
    for (i = 0; i < 2; i++) begin
      lag = i ? 4'h0 : 4'h6;
      irq_req_in = 1'b1;
      step();
      irq_req_in = 1'b0;
      wait_for(0, 8);
      chk("mwr_addr", {~d, d & 32'hfffffffc}, mwr_addr_out);
      chk("mwr_data", d[15:0], mwr_data_out);
      chk("intx", 1'b0, intx_out);
      step(12);
      chk("mwr_req", 1'b0, mwr_req_out);
    end
    // Second interrupt while the first write is pending is sent after it
    irq_req_in = 1'b1;
    step(2);
    irq_req_in = 1'b0;
    repeat (40) begin
      if (mwr_req_out === 1'b1 && p !== 1'b1) begin
        rises++;
      end
      p = mwr_req_out;
      step();
    end
    chk("mwr_count", 2, rises);
    wr(8'h8c, 4'h4, 32'h0);
    irq_req_in = 1'b1;
    step();
    irq_req_in = 1'b0;
    wait_for(1, 4);
    chk("mwr_req", 1'b0, mwr_req_out);
    wr(8'h84, 4'h1, 32'h0);
    wait_for(2, 4);
    step(10);
    rd(8'h90, 32'hffffffff, 32'h0);
    eeprom_nosoft_in = 1'b1;
    eeprom_load_in   = 1'b1;
    step();
    eeprom_load_in = 1'b0;
    rd(8'h84, 32'h00000008, 32'h8);
    wr(8'h84, 4'h1, 32'h3);
    wr(8'h84, 4'h1, 32'h0);
    repeat (12) begin
      step();
      chk("hot_reset", 1'b0, hot_reset_out);
    end
    // Pin reset clears the loaded skip flag and the stored address
    wr(8'h94, 4'hf, d);
    fund_rst_n = 1'b0;
    step(6);
    fund_rst_n = 1'b1;
    step(6);
    rd(8'h84, 32'hffffffff, 32'h0);
    rd(8'h94, 32'hffffffff, 32'h0);
    print_verdict();
  end
endmodule
